// ===== hdl/acd_defs.svh
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH

// FIFO shape and DWORD counter
`define ACD_FIFO_DEPTH   6'h23
`define ACD_FIFO_WIDTH   36
`define ACD_LVL_W        6
`define ACD_PTR_LAST     6'h22
`define ACD_LANES_ALL    4'hF

// Instruction fields
`define ACD_OP_HI        31
`define ACD_OP_LO        28
`define ACD_CNT_HI       11
`define ACD_CNT_LO       0
`define ACD_OP_WRITE     4'h1
`define ACD_OP_JUMP      4'h7

// Address step per DWORD
`define ACD_DW_STEP      32'h0000_0004

// Sample packing
`define ACD_SLOT_LAST8   2'h3

`endif

// ===== hdl/acd_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "acd_defs.svh"

module acd_fifo
   import acd_pkg::*;
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       push_i,
   input  wire logic [`ACD_FIFO_WIDTH-1:0] wdata_i,
   input  wire logic                       pop_i,
   output logic      [`ACD_FIFO_WIDTH-1:0] rdata_o,
   output logic      [`ACD_LVL_W-1:0]      level_o,
   output logic                            full_o,
   output logic                            empty_o
);

   logic [`ACD_FIFO_WIDTH-1:0] mem [0:`ACD_FIFO_DEPTH-1];
   logic [`ACD_LVL_W-1:0]      wr_ptr;
   logic [`ACD_LVL_W-1:0]      rd_ptr;
   logic [`ACD_LVL_W-1:0]      next_wr_ptr;
   logic [`ACD_LVL_W-1:0]      next_rd_ptr;
   logic [`ACD_LVL_W-1:0]      next_level;
   logic                       do_push;
   logic                       do_pop;

   assign full_o  = (level_o == `ACD_FIFO_DEPTH);
   assign empty_o = (level_o == '0);
   assign rdata_o = mem[rd_ptr];

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      do_push     = push_i && !full_o;
      do_pop      = pop_i && !empty_o;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_level  = level_o;
      if (do_push)
      begin
         next_wr_ptr = (wr_ptr == `ACD_PTR_LAST) ? '0 : wr_ptr + 6'h01;
      end
      if (do_pop)
      begin
         next_rd_ptr = (rd_ptr == `ACD_PTR_LAST) ? '0 : rd_ptr + 6'h01;
      end
      if (do_push && !do_pop)
      begin
         next_level = level_o + 6'h01;
      end
      else if (do_pop && !do_push)
      begin
         next_level = level_o - 6'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         level_o <= '0;
      end
      else
      begin
         wr_ptr  <= next_wr_ptr;
         rd_ptr  <= next_rd_ptr;
         level_o <= next_level;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (do_push)
      begin
         mem[wr_ptr] <= wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   level_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      level_o <= `ACD_FIFO_DEPTH)
      else $error("fifo level above depth");

   pop_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (pop_i && !push_i && !empty_o) |=> level_o == $past(level_o) - 6'h01)
      else $error("pop did not lower the dword count");

endmodule
`default_nettype wire

// ===== hdl/acd_pkg.sv
`default_nettype none
package acd_pkg;

   typedef enum logic [1:0]
   {
      ACD_ST_IDLE,
      ACD_ST_FETCH_OP,
      ACD_ST_FETCH_ARG,
      ACD_ST_WRITE
   } acd_state_t;

endpackage
`default_nettype wire

// ===== hdl/acd_top.sv
// Notes on behaviour
// - Samples of 8 or 16 bits are packed into 32-bit DWORDs for memory.
// - Own instruction list drives the channel, independent of any video flow.
// - Samples move continuously; no sync gaps are inserted in the stream.
// - Only packed write and jump instructions execute; others flag an error and restart from start_addr_i.
// - One FIFO of 35 by 36 bits with a 6-bit DWORD count.
// - Master port offers the same request, grant and handshake as video.
// - A retry only backs off this initiator; it drops the request for one cycle, then re-requests.
// - All control inputs live in the bus clock domain, none in audio.
// - Control is taken every cycle without stall, retry or disconnect.
// - Error conditions are flagged for the host side: overrun_o as a level until enable drops, bad_instr_o as a one-cycle pulse while enable stays high.
// - Sampling at 40 MHz sustains 8 Mbps digital audio without loss.
`timescale 1ns/100ps
`default_nettype none
`include "acd_defs.svh"

module acd_top
   import acd_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        enable_i,
   input  wire logic        wide_i,
   input  wire logic [31:0] start_addr_i,
   input  wire logic        aud_clk_i,
   input  wire logic [15:0] aud_data_i,
   output logic             mst_req_o,
   input  wire logic        mst_gnt_i,
   output logic             mst_valid_o,
   output logic             mst_read_o,
   output logic [31:0]      mst_addr_o,
   output logic [31:0]      mst_wdata_o,
   output logic [3:0]       mst_be_o,
   input  wire logic        mst_ready_i,
   input  wire logic        mst_retry_i,
   input  wire logic [31:0] mst_rdata_i,
   output logic [5:0]       fifo_level_o,
   output logic             overrun_o,
   output logic             bad_instr_o,
   output logic             busy_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rst_s1;
   logic rst;

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1 <= 1'b0;
         rst    <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst    <= rst_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Audio pin capture
   logic        aclk_s1;
   logic        aclk_s2;
   logic        aclk_s3;
   logic [15:0] adat_s1;
   logic [15:0] adat_s2;
   logic        a_rise;

   always_ff @(posedge sys_clk_i or negedge rst)
   begin
      if (!rst)
      begin
         aclk_s1 <= 1'b0;
         aclk_s2 <= 1'b0;
         aclk_s3 <= 1'b0;
         adat_s1 <= '0;
         adat_s2 <= '0;
      end
      else
      begin
         aclk_s1 <= aud_clk_i;
         aclk_s2 <= aclk_s1;
         aclk_s3 <= aclk_s2;
         adat_s1 <= aud_data_i;
         adat_s2 <= adat_s1;
      end
   end

   assign a_rise = aclk_s2 && !aclk_s3;

   ////////////////////////////////////////////////////////////////////////////
   // Sample packer
   logic [1:0]  slot;
   logic [31:0] word;
   logic        push;
   logic [35:0] push_data;
   logic [1:0]  next_slot;
   logic [31:0] next_word;
   logic        next_push;
   logic [35:0] next_push_data;
   logic        next_overrun;
   logic        last;
   logic        f_full;
   logic        f_empty;
   logic [35:0] f_head;
   logic        pop;

   always_comb
   begin
      next_slot      = slot;
      next_word      = word;
      next_push      = 1'b0;
      next_push_data = push_data;
      next_overrun   = overrun_o;
      last           = wide_i ? slot[0] : (slot == `ACD_SLOT_LAST8);
      if (!enable_i)
      begin
         next_slot    = '0;
         next_overrun = 1'b0;
      end
      else if (a_rise)
      begin
         if (wide_i)
         begin
            next_word[slot[0]*16 +: 16] = adat_s2;
         end
         else
         begin
            next_word[slot*8 +: 8] = adat_s2[7:0];
         end
         next_slot = last ? 2'h0 : slot + 2'h1;
         if (last)
         begin
            next_push      = 1'b1;
            next_push_data = {`ACD_LANES_ALL, next_word};
         end
      end
      if (push && f_full)
      begin
         next_overrun = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst)
   begin
      if (!rst)
      begin
         slot      <= '0;
         word      <= '0;
         push      <= 1'b0;
         push_data <= '0;
         overrun_o <= 1'b0;
      end
      else
      begin
         slot      <= next_slot;
         word      <= next_word;
         push      <= next_push;
         push_data <= next_push_data;
         overrun_o <= next_overrun;
      end
   end

   acd_fifo u_fifo
   (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst),
      .push_i  (push),
      .wdata_i (push_data),
      .pop_i   (pop),
      .rdata_o (f_head),
      .level_o (fifo_level_o),
      .full_o  (f_full),
      .empty_o (f_empty)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Instruction engine and bus master
   acd_state_t state;
   acd_state_t next_state;
   logic [31:0] pc;
   logic [31:0] next_pc;
   logic [3:0]  op;
   logic [3:0]  next_op;
   logic [11:0] left;
   logic [11:0] next_left;
   logic        next_req;
   logic        next_valid;
   logic        next_read;
   logic [31:0] next_addr;
   logic [31:0] next_wdata;
   logic [3:0]  next_be;
   logic        next_bad;
   logic        accept;
   logic        retry_hit;

   always_comb
   begin
      next_state = state;
      next_pc    = pc;
      next_op    = op;
      next_left  = left;
      next_req   = mst_req_o;
      next_valid = mst_valid_o;
      next_read  = mst_read_o;
      next_addr  = mst_addr_o;
      next_wdata = mst_wdata_o;
      next_be    = mst_be_o;
      next_bad   = bad_instr_o;
      pop        = 1'b0;
      accept     = mst_req_o && mst_valid_o && mst_gnt_i && mst_ready_i && !mst_retry_i;
      retry_hit  = mst_req_o && mst_valid_o && mst_gnt_i && mst_retry_i;
      if (mst_valid_o && !mst_req_o)
      begin
         next_req = 1'b1;
      end
      if (retry_hit)
      begin
         next_req = 1'b0;
      end
      unique case (state)
         ACD_ST_IDLE:
         begin
            if (enable_i)
            begin
               next_state = ACD_ST_FETCH_OP;
               next_pc    = start_addr_i;
               next_addr  = start_addr_i;
               next_req   = 1'b1;
               next_valid = 1'b1;
               next_read  = 1'b1;
               next_be    = `ACD_LANES_ALL;
               next_bad   = 1'b0;
            end
         end
         ACD_ST_FETCH_OP:
         begin
            if (accept)
            begin
               next_op   = mst_rdata_i[`ACD_OP_HI:`ACD_OP_LO];
               next_left = mst_rdata_i[`ACD_CNT_HI:`ACD_CNT_LO];
               next_pc   = pc + `ACD_DW_STEP;
               next_addr = pc + `ACD_DW_STEP;
               if (mst_rdata_i[`ACD_OP_HI:`ACD_OP_LO] == `ACD_OP_WRITE ||
                   mst_rdata_i[`ACD_OP_HI:`ACD_OP_LO] == `ACD_OP_JUMP)
               begin
                  next_state = ACD_ST_FETCH_ARG;
               end
               else
               begin
                  next_bad   = 1'b1;
                  next_state = ACD_ST_IDLE;
                  next_req   = 1'b0;
                  next_valid = 1'b0;
                  next_read  = 1'b0;
               end
            end
         end
         ACD_ST_FETCH_ARG:
         begin
            if (accept)
            begin
               if (op == `ACD_OP_JUMP)
               begin
                  next_pc    = mst_rdata_i;
                  next_addr  = mst_rdata_i;
                  next_state = ACD_ST_FETCH_OP;
               end
               else if (left == '0)
               begin
                  next_pc    = pc + `ACD_DW_STEP;
                  next_addr  = pc + `ACD_DW_STEP;
                  next_state = ACD_ST_FETCH_OP;
               end
               else
               begin
                  next_pc    = pc + `ACD_DW_STEP;
                  next_addr  = mst_rdata_i;
                  next_state = ACD_ST_WRITE;
                  next_req   = 1'b0;
                  next_valid = 1'b0;
                  next_read  = 1'b0;
               end
            end
         end
         ACD_ST_WRITE:
         begin
            if (accept)
            begin
               next_left  = left - 12'h001;
               next_valid = 1'b0;
               next_req   = 1'b0;
               next_addr  = mst_addr_o + `ACD_DW_STEP;
               if (left == 12'h001)
               begin
                  next_state = ACD_ST_FETCH_OP;
                  next_addr  = pc;
                  next_valid = 1'b1;
                  next_req   = 1'b1;
                  next_read  = 1'b1;
               end
            end
            else if (!mst_valid_o && !f_empty)
            begin
               pop        = 1'b1;
               next_wdata = f_head[31:0];
               next_be    = f_head[35:32];
               next_valid = 1'b1;
               next_req   = 1'b1;
            end
         end
      endcase
      if (!enable_i)
      begin
         next_state = ACD_ST_IDLE;
         next_req   = 1'b0;
         next_valid = 1'b0;
         next_read  = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst)
   begin
      if (!rst)
      begin
         state       <= ACD_ST_IDLE;
         pc          <= '0;
         op          <= '0;
         left        <= '0;
         mst_req_o   <= 1'b0;
         mst_valid_o <= 1'b0;
         mst_read_o  <= 1'b0;
         mst_addr_o  <= '0;
         mst_wdata_o <= '0;
         mst_be_o    <= '0;
         bad_instr_o <= 1'b0;
         busy_o      <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         pc          <= next_pc;
         op          <= next_op;
         left        <= next_left;
         mst_req_o   <= next_req;
         mst_valid_o <= next_valid;
         mst_read_o  <= next_read;
         mst_addr_o  <= next_addr;
         mst_wdata_o <= next_wdata;
         mst_be_o    <= next_be;
         bad_instr_o <= next_bad;
         busy_o      <= (next_state != ACD_ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   retry_backoff_a: assert property (@(posedge sys_clk_i) disable iff (!rst)
      (retry_hit && enable_i) |=> !mst_req_o && mst_valid_o ##1 mst_req_o)
      else $error("retry did not back off for exactly one cycle");

   write_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst)
      (state == ACD_ST_WRITE && mst_valid_o && !accept && enable_i)
      |=> mst_valid_o && $stable(mst_wdata_o) && $stable(mst_addr_o))
      else $error("write data dropped before acceptance");

   data_request_a: assert property (@(posedge sys_clk_i) disable iff (!rst)
      (state == ACD_ST_WRITE && !mst_valid_o && !f_empty && enable_i)
      |=> mst_valid_o && mst_req_o && !mst_read_o)
      else $error("stored data did not raise a request");

   fetch_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst)
      (mst_valid_o && (state == ACD_ST_FETCH_OP || state == ACD_ST_FETCH_ARG))
      |-> mst_read_o)
      else $error("instruction fetch not issued as read");

   bad_op_a: assert property (@(posedge sys_clk_i) disable iff (!rst)
      (state == ACD_ST_FETCH_OP && accept && enable_i &&
       mst_rdata_i[`ACD_OP_HI:`ACD_OP_LO] != `ACD_OP_WRITE &&
       mst_rdata_i[`ACD_OP_HI:`ACD_OP_LO] != `ACD_OP_JUMP)
      |=> bad_instr_o && state == ACD_ST_IDLE && !mst_req_o)
      else $error("unsupported instruction not halted");

   pack_push_a: assert property (@(posedge sys_clk_i) disable iff (!rst)
      (a_rise && enable_i && wide_i && slot == 2'h1)
      |=> push && push_data[31:16] == $past(adat_s2))
      else $error("16-bit pair not pushed as dword");

   gapless_a: assert property (@(posedge sys_clk_i) disable iff (!rst)
      (a_rise && enable_i && !wide_i && slot == `ACD_SLOT_LAST8)
      |=> push ##1 !push)
      else $error("packed byte word not pushed once");

   overrun_a: assert property (@(posedge sys_clk_i) disable iff (!rst)
      (push && f_full && enable_i) |=> overrun_o)
      else $error("push into full fifo not flagged");

endmodule
`default_nettype wire

// ===== verif/acd_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module acd_host_model
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        req_i,
   input  wire logic        valid_i,
   input  wire logic        read_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  be_i,
   output logic             gnt_o,
   output logic             ready_o,
   output logic             retry_o,
   output logic [31:0]      rdata_o
);

   // Memory and logs of completed beats
   logic [31:0] mem [bit [31:0]];
   logic [31:0] wa_q[$];
   logic [31:0] wd_q[$];
   logic [31:0] ra_q[$];
   logic [3:0]  be_q[$];
   int          delay   = 0;
   int          retries = 0;
   int          cnt     = 0;
   logic        gnt_en  = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gnt_o   <= 1'b0;
         ready_o <= 1'b0;
         retry_o <= 1'b0;
         rdata_o <= 32'h0;
      end
      else
      begin
         gnt_o   <= req_i & gnt_en;
         ready_o <= 1'b0;
         retry_o <= 1'b0;
         rdata_o <= ~rdata_o;
         if (ready_o | retry_o)
         begin
            cnt = 0;
            if (ready_o & !retry_o & req_i & valid_i & gnt_o)
            begin
               if (read_i)
                  ra_q.push_back(addr_i);
               else
               begin
                  wa_q.push_back(addr_i);
                  wd_q.push_back(wdata_i);
                  be_q.push_back(be_i);
               end
            end
         end
         else if (req_i & valid_i & gnt_o)
         begin
            if (cnt < delay)
               cnt++;
            else if (!read_i && retries > 0)
            begin
               // Target retries a write beat
               retry_o <= 1'b1;
               retries--;
            end
            else
            begin
               ready_o <= 1'b1;
               rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 32'hFFFF_FFFF;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== verif/tb_audio_capture_dma_channel.sv
`timescale 1ns/100ps
`default_nettype none

module tb_audio_capture_dma_channel;

   logic        sys_clk, rst_n, enable, wide, aud_clk, aud_on;
   logic [31:0] start_addr, wdata, addr, rdata;
   logic [15:0] aud_data;
   logic        req, gnt, valid, rd, ready, retry, overrun, bad_instr, busy;
   logic [3:0]  be;
   logic [5:0]  level;
   logic [2:0]  phase;
   int          rises, n_samp, n_mismatch, samples_checked;

   acd_top i_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .enable_i(enable), .wide_i(wide),
      .start_addr_i(start_addr), .aud_clk_i(aud_clk), .aud_data_i(aud_data),
      .mst_req_o(req), .mst_gnt_i(gnt), .mst_valid_o(valid), .mst_read_o(rd),
      .mst_addr_o(addr), .mst_wdata_o(wdata), .mst_be_o(be), .mst_ready_i(ready),
      .mst_retry_i(retry), .mst_rdata_i(rdata), .fifo_level_o(level),
      .overrun_o(overrun), .bad_instr_o(bad_instr), .busy_o(busy));

   acd_host_model i_host (.clk_i(sys_clk), .rst_n_i(rst_n), .req_i(req), .valid_i(valid),
      .read_i(rd), .addr_i(addr), .wdata_i(wdata), .be_i(be), .gnt_o(gnt),
      .ready_o(ready), .retry_o(retry), .rdata_o(rdata));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   function automatic logic [15:0] samp(input int k);
      return {8'hC0 + 8'(k), 8'h10 + 8'(k)};
   endfunction

   function automatic logic [31:0] edw(input int j, input logic w);
      if (w)
         return {samp(2 * j + 1), samp(2 * j)};
      return {8'h10 + 8'(4 * j + 3), 8'h10 + 8'(4 * j + 2), 8'h10 + 8'(4 * j + 1),
              8'h10 + 8'(4 * j)};
   endfunction

   // Audio clock of 200 ns, running only while samples are sent
   always @(posedge sys_clk)
   begin
      if (aud_on)
      begin
         phase <= phase + 3'h1;
         if (phase == 3'h0 && rises < n_samp)
         begin
            aud_clk <= 1'b1;
            rises   <= rises + 1;
         end
         if (phase == 3'h4)
         begin
            aud_clk  <= 1'b0;
            aud_data <= (rises < n_samp) ? samp(rises) : ~aud_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic begin_run(input logic w, input logic [31:0] p, input int ns);
      i_host.wa_q.delete();
      i_host.wd_q.delete();
      i_host.ra_q.delete();
      i_host.be_q.delete();
      @(posedge sys_clk);
      wide       <= w;
      start_addr <= p;
      @(posedge sys_clk);
      enable   <= 1'b1;
      aud_data <= samp(0);
      rises    <= 0;
      phase    <= 3'h1;
      n_samp   <= ns;
      aud_on   <= 1'b1;
   endtask

   task automatic stop_run;
      @(posedge sys_clk);
      enable <= 1'b0;
      aud_on <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic wait_wr(input int n);
      for (int i = 0; i < 3000 && i_host.wa_q.size() < n; i++)
         @(posedge sys_clk);
   endtask

   task automatic wait_bad;
      for (int i = 0; i < 300 && bad_instr !== 1'b1; i++)
         @(posedge sys_clk);
   endtask

   task automatic check_writes(input int n, input logic [31:0] base, input logic w);
      check(32'(i_host.wa_q.size()), 32'(n), "write count");
      for (int j = 0; j < n && j < i_host.wa_q.size(); j++)
      begin
         check(i_host.wa_q[j], base + 32'(4 * j), "write address");
         check(i_host.wd_q[j], edw(j, w), "packed data");
         check(32'(i_host.be_q[j]), 32'hF, "byte enables");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_pack8;
      i_host.mem[32'h0000_1000] = 32'h1000_0003;
      i_host.mem[32'h0000_1004] = 32'h0002_0000;
      i_host.mem[32'h0000_1008] = 32'hF000_0000;
      begin_run(1'b0, 32'h0000_1000, 12);
      wait_wr(3);
      check_writes(3, 32'h0002_0000, 1'b0);
      wait_bad;
      check(32'(bad_instr), 32'h1, "halt on bad opcode");
      check(i_host.ra_q[0], 32'h0000_1000, "first fetch");
      check(i_host.ra_q[1], 32'h0000_1004, "argument fetch");
      check(32'(level), 32'h0, "fifo drained");
      stop_run;
   endtask

   task automatic t_pack16_retry;
      logic [31:0] exp_rd [6] = '{32'h2000, 32'h2004, 32'h2008, 32'h200C, 32'h3000, 32'h3004};
      i_host.mem[32'h0000_2000] = 32'h1000_0002;
      i_host.mem[32'h0000_2004] = 32'h0004_0000;
      i_host.mem[32'h0000_2008] = 32'h7000_0000;
      i_host.mem[32'h0000_200C] = 32'h0000_3000;
      i_host.mem[32'h0000_3000] = 32'h1000_0000;
      i_host.mem[32'h0000_3004] = 32'h0005_0000;
      i_host.mem[32'h0000_3008] = 32'h4000_0000;
      i_host.delay   = 3;
      i_host.retries = 2;
      begin_run(1'b1, 32'h0000_2000, 4);
      repeat (4) @(posedge sys_clk);
      check(32'(bad_instr), 32'h0, "error cleared on start");
      wait_wr(2);
      check_writes(2, 32'h0004_0000, 1'b1);
      check(32'(i_host.retries), 32'h0, "retries consumed");
      wait_bad;
      for (int i = 0; i < 6 && i < i_host.ra_q.size(); i++)
         check(i_host.ra_q[i], exp_rd[i], "fetch order with jump and skip");
      check(32'(overrun), 32'h0, "no loss");
      stop_run;
      i_host.delay = 0;
   endtask

   task automatic t_overrun;
      i_host.mem[32'h0000_4000] = 32'h1000_0028;
      i_host.mem[32'h0000_4004] = 32'h0006_0000;
      i_host.gnt_en <= 1'b0;
      begin_run(1'b0, 32'h0000_4000, 4 * 38);
      repeat (4 * 38 * 8 + 40) @(posedge sys_clk);
      check(32'(level), 32'h23, "fifo full count");
      check(32'(overrun), 32'h1, "overrun flagged");
      check(32'(req), 32'h1, "request while data held");
      check(32'(busy), 32'h1, "busy while running");
      i_host.gnt_en <= 1'b1;
      wait_wr(30);
      check(i_host.wd_q[0], edw(0, 1'b0), "oldest data first");
      check(i_host.wa_q[29], 32'h0006_0000 + 32'h74, "burst address");
      stop_run;
      check(32'(overrun), 32'h0, "overrun cleared");
      check(32'({busy, req, valid}), 32'h0, "idle after disable");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      enable = 1'b0;
      wide = 1'b0;
      start_addr = 32'h0;
      aud_clk = 1'b0;
      aud_data = 16'h0;
      aud_on = 1'b0;
      phase = 3'h0;
      rises = 0;
      n_samp = 0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      t_pack8;
      t_pack16_retry;
      t_overrun;
      give_verdict;
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      give_verdict;
   end

endmodule

`default_nettype wire
